// ### cmc_defines.vh
// Purpose: shared constants of the master control block
// Assumes: byte addresses on a 32-bit register port
// Notes: definitions only
`ifndef CMC_DEFINES_VH
`define CMC_DEFINES_VH

// register map
`define CMC_AW 8
`define CMC_ADDR_CTRL 8'h00
`define CMC_ADDR_STAT 8'h04

// control field positions
`define CMC_BIT_CFG_REQ 12
`define CMC_BIT_PDN_REQ 11
`define CMC_BIT_ORDER 10
`define CMC_BIT_WAKE 9
`define CMC_BIT_UPD_REQ 8
`define CMC_BIT_AUTO_ON 7
`define CMC_BIT_SELF_TEST 6
`define CMC_BIT_SWRST 5
`define CMC_MBX_HI 4
`define CMC_MBX_LO 0

// status field positions
`define CMC_ST_PDOWN 0
`define CMC_ST_BUSOFF 1
`define CMC_ST_RECOV 2
`define CMC_ST_CANCEL 3

// reset values
`define CMC_RST_BIT 1'b0
`define CMC_RST_MBX 5'h00
`define CMC_RST_WORD 32'h00000000
`define CMC_RST_RECESSIVE 1'b1
`define CMC_RST_LANE 3'h0

// mailbox numbers and byte lanes
`define CMC_MBX_ZERO 5'h00
`define CMC_BYTE_LAST 3'h7

// bus-off recovery: 128 groups of 11 recessive bits
`define CMC_RECOV_BITS 11'h580
`define CMC_CNT_ZERO 11'h000
`define CMC_CNT_ONE 11'h001

`endif

// ### cmc_recessive_counter.v
// Purpose: counts consecutive recessive bits during bus-off
// Assumes: bit_tick pulses once per sampled bus bit
// Notes: any dominant bit restarts the count
`timescale 1ns/1ps
`include "cmc_defines.vh"

module cmc_recessive_counter (
	clk_sys,
	rst_n,
	enable,
	bit_tick,
	rx_bit,
	done
);
	input wire clk_sys;
	input wire rst_n;
	input wire enable;
	input wire bit_tick;
	input wire rx_bit;
	output wire done;

	reg [10:0] cnt_q;

	assign done = (cnt_q == `CMC_RECOV_BITS);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= `CMC_CNT_ZERO;
		end else if (!enable) begin
			cnt_q <= `CMC_CNT_ZERO;
		end else if (bit_tick) begin
			if (!rx_bit) begin
				cnt_q <= `CMC_CNT_ZERO;
			end else if (!done) begin
				cnt_q <= cnt_q + `CMC_CNT_ONE;
			end
		end
	end
endmodule

// ### cmc_master_control.v
// Purpose: low bits of the can master control register
// Assumes: bit engine, mailbox logic and filter on the same clock
// Notes: can_rx is a pin and is synchronised here
//
// Contract
// - byte order select picks lsb or msb first
// - protected bits written only under write privilege
// - bus activity wakes when wake enable set
// - otherwise stay down until request cleared
// - no transmit of selected mailbox during update
// - pending transmit keeps old data; software re-requests
// - auto bus-on after 128x11 recessive bits
// - else also needs config request cleared
// - self test: own ack, no drive, loop back
// - self test: identifier not stored
// - self test: unconfigured receive goes to mailbox zero
// - self test: unmatched frame discarded
// - software reset bit reads zero, zero ignored
// - software reset restores unprotected defaults only
// - software reset cancels transmits at idle bus
// - mailbox number field, top bit enhanced only
// - wake clears power-down request
// - bus-off without auto bus-on sets config request
// - compatibility mode limits mailbox numbers to fifteen
`timescale 1ns/1ps
`include "cmc_defines.vh"

module cmc_master_control (
	clk_sys,
	rst_n,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	protected_write_privilege,
	compatibility_mode,
	can_rx,
	can_tx,
	bit_tick,
	bus_idle,
	bus_off_entry,
	tx_bit,
	tx_check_valid,
	tx_check_mailbox,
	tx_check_block,
	tx_byte_index,
	tx_byte_lane,
	rx_byte_index,
	rx_byte_lane,
	byte_order_select,
	loop_frame_done,
	rx_any_configured,
	rx_match_valid,
	rx_match_mailbox,
	loop_store,
	loop_mailbox,
	loop_discard,
	id_store_enable,
	self_ack_enable,
	powered_down,
	bus_off,
	soft_reset,
	tx_cancel
);
	input wire clk_sys;
	input wire rst_n;
	input wire [7:0] reg_addr;
	input wire [31:0] reg_wdata;
	input wire reg_wr;
	input wire reg_rd;
	output reg [31:0] reg_rdata;
	input wire protected_write_privilege;
	input wire compatibility_mode;
	input wire can_rx;
	output reg can_tx;
	input wire bit_tick;
	input wire bus_idle;
	input wire bus_off_entry;
	input wire tx_bit;
	input wire tx_check_valid;
	input wire [4:0] tx_check_mailbox;
	output wire tx_check_block;
	input wire [2:0] tx_byte_index;
	output reg [2:0] tx_byte_lane;
	input wire [2:0] rx_byte_index;
	output reg [2:0] rx_byte_lane;
	output wire byte_order_select;
	input wire loop_frame_done;
	input wire rx_any_configured;
	input wire rx_match_valid;
	input wire [4:0] rx_match_mailbox;
	output reg loop_store;
	output reg [4:0] loop_mailbox;
	output reg loop_discard;
	output wire id_store_enable;
	output wire self_ack_enable;
	output wire powered_down;
	output wire bus_off;
	output wire soft_reset;
	output wire tx_cancel;

	// control state
	reg cfg_req_q;
	reg pdn_req_q;
	reg lsb_first_q;
	reg wake_en_q;
	reg upd_req_q;
	reg auto_on_q;
	reg self_test_q;
	reg [4:0] upd_mbx_q;

	// block state
	reg pdown_q;
	reg bus_off_q;
	reg swrst_q;
	reg cancel_pend_q;
	reg cancel_q;
	reg rx_meta_q;
	reg rx_sync_q;

	wire wr_ctrl;
	wire rd_hit_ctrl;
	wire rd_hit_stat;
	wire prot_ok;
	wire swrst_wr;
	wire wake_event;
	wire recov_done;
	wire leave_bus_off;
	wire [31:0] ctrl_word;
	wire [31:0] stat_word;

	// mailbox number limited to fifteen in compatibility mode
	function [4:0] cmc_mbx_num;
		input [4:0] num;
		input compat;
		begin
			cmc_mbx_num = num;
			if (compat) begin
				cmc_mbx_num[`CMC_MBX_HI] = 1'b0;
			end
		end
	endfunction

	// byte lane of a data byte for the selected order
	function [2:0] cmc_lane;
		input [2:0] idx;
		input lsb_first;
		begin
			if (lsb_first) begin
				cmc_lane = idx;
			end else begin
				cmc_lane = `CMC_BYTE_LAST - idx;
			end
		end
	endfunction

	assign wr_ctrl = reg_wr && (reg_addr == `CMC_ADDR_CTRL);
	assign rd_hit_ctrl = reg_addr == `CMC_ADDR_CTRL;
	assign rd_hit_stat = reg_addr == `CMC_ADDR_STAT;
	assign prot_ok = wr_ctrl && protected_write_privilege;
	assign swrst_wr = wr_ctrl && reg_wdata[`CMC_BIT_SWRST];

	// rx pin synchroniser
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_meta_q <= `CMC_RST_RECESSIVE;
			rx_sync_q <= `CMC_RST_RECESSIVE;
		end else begin
			rx_meta_q <= can_rx;
			rx_sync_q <= rx_meta_q;
		end
	end

	// dominant level seen while powered down
	assign wake_event = pdown_q && wake_en_q && !rx_sync_q;

	// protected control bits
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lsb_first_q <= `CMC_RST_BIT;
			wake_en_q <= `CMC_RST_BIT;
			auto_on_q <= `CMC_RST_BIT;
			self_test_q <= `CMC_RST_BIT;
		end else if (prot_ok) begin
			lsb_first_q <= reg_wdata[`CMC_BIT_ORDER];
			wake_en_q <= reg_wdata[`CMC_BIT_WAKE];
			auto_on_q <= reg_wdata[`CMC_BIT_AUTO_ON];
			self_test_q <= reg_wdata[`CMC_BIT_SELF_TEST];
		end
	end

	// config request: hardware set wins over software clear
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_req_q <= `CMC_RST_BIT;
		end else if (bus_off_entry && !auto_on_q) begin
			cfg_req_q <= 1'b1;
		end else if (prot_ok) begin
			cfg_req_q <= reg_wdata[`CMC_BIT_CFG_REQ];
		end
	end

	// power-down request and state
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pdn_req_q <= `CMC_RST_BIT;
		end else if (prot_ok) begin
			pdn_req_q <= reg_wdata[`CMC_BIT_PDN_REQ];
		end else if (wake_event) begin
			pdn_req_q <= 1'b0;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pdown_q <= `CMC_RST_BIT;
		end else if (pdown_q) begin
			if (wake_event) begin
				pdown_q <= 1'b0;
			end else if (!pdn_req_q) begin
				pdown_q <= 1'b0;
			end
		end else if (pdn_req_q && bus_idle) begin
			pdown_q <= 1'b1;
		end
	end

	// unprotected bits, returned to defaults by software reset
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			upd_req_q <= `CMC_RST_BIT;
			upd_mbx_q <= `CMC_RST_MBX;
		end else if (swrst_wr) begin
			upd_req_q <= `CMC_RST_BIT;
			upd_mbx_q <= `CMC_RST_MBX;
		end else if (wr_ctrl) begin
			upd_req_q <= reg_wdata[`CMC_BIT_UPD_REQ];
			upd_mbx_q <= cmc_mbx_num(reg_wdata[`CMC_MBX_HI:`CMC_MBX_LO],
				compatibility_mode);
		end
	end

	// engine asks before and after the buffer copy
	assign tx_check_block = tx_check_valid && upd_req_q &&
		(tx_check_mailbox == cmc_mbx_num(upd_mbx_q, compatibility_mode));
	// only the copy is gated; a pending request is never reloaded

	// bus-off and recovery
	cmc_recessive_counter u_recov (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.enable(bus_off_q),
		.bit_tick(bit_tick),
		.rx_bit(rx_sync_q),
		.done(recov_done)
	);

	assign leave_bus_off = recov_done && (auto_on_q || !cfg_req_q);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_off_q <= `CMC_RST_BIT;
		end else if (bus_off_entry) begin
			bus_off_q <= 1'b1;
		end else if (leave_bus_off) begin
			bus_off_q <= 1'b0;
		end
	end

	// software reset pulse and cancel at idle bus
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			swrst_q <= `CMC_RST_BIT;
			cancel_pend_q <= `CMC_RST_BIT;
			cancel_q <= `CMC_RST_BIT;
		end else begin
			swrst_q <= swrst_wr;
			cancel_q <= cancel_pend_q && bus_idle;
			if (swrst_wr) begin
				cancel_pend_q <= 1'b1;
			end else if (bus_idle) begin
				cancel_pend_q <= 1'b0;
			end
		end
	end

	// tx pin: recessive in self test, power-down and bus-off
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			can_tx <= `CMC_RST_RECESSIVE;
		end else if (self_test_q || pdown_q || bus_off_q) begin
			can_tx <= 1'b1;
		end else begin
			can_tx <= tx_bit;
		end
	end

	// byte lanes for the data field
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_byte_lane <= `CMC_RST_LANE;
			rx_byte_lane <= `CMC_RST_LANE;
		end else begin
			tx_byte_lane <= cmc_lane(tx_byte_index, lsb_first_q);
			rx_byte_lane <= cmc_lane(rx_byte_index, lsb_first_q);
		end
	end

	// looped-back frame placement in self test
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			loop_store <= 1'b0;
			loop_discard <= 1'b0;
			loop_mailbox <= `CMC_MBX_ZERO;
		end else begin
			loop_store <= 1'b0;
			loop_discard <= 1'b0;
			if (loop_frame_done && self_test_q) begin
				if (!rx_any_configured) begin
					loop_store <= 1'b1;
					loop_mailbox <= `CMC_MBX_ZERO;
				end else if (rx_match_valid) begin
					loop_store <= 1'b1;
					loop_mailbox <= rx_match_mailbox;
				end else begin
					loop_discard <= 1'b1;
				end
			end
		end
	end

	assign id_store_enable = !self_test_q;
	assign self_ack_enable = self_test_q;

	// register readback; software reset bit always zero
	assign ctrl_word = {19'h00000, cfg_req_q, pdn_req_q, lsb_first_q,
		wake_en_q, upd_req_q, auto_on_q, self_test_q, 1'b0,
		cmc_mbx_num(upd_mbx_q, compatibility_mode)};
	assign stat_word = {28'h0000000, cancel_pend_q, recov_done,
		bus_off_q, pdown_q};

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `CMC_RST_WORD;
		end else if (reg_rd && rd_hit_ctrl) begin
			reg_rdata <= ctrl_word;
		end else if (reg_rd && rd_hit_stat) begin
			reg_rdata <= stat_word;
		end else begin
			reg_rdata <= `CMC_RST_WORD;
		end
	end

	assign byte_order_select = lsb_first_q;
	assign powered_down = pdown_q;
	assign bus_off = bus_off_q;
	assign soft_reset = swrst_q;
	assign tx_cancel = cancel_q;
endmodule

// ### cmc_bus_model.sv
// Purpose: can bus as seen from the node
// Assumes: one bus bit sampled every other clock
// Notes: other nodes pull dominant on request
`timescale 1ns/1ps
module cmc_bus_model (
	input wire clk_sys,
	input wire rst_n,
	input wire can_tx,
	input wire other_dom,
	output wire can_rx,
	output reg bit_tick
);
	// wired-and, dominant wins
	assign can_rx = can_tx & ~other_dom;
	// bit sampling pace
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			bit_tick <= 1'b0;
		else
			bit_tick <= ~bit_tick;
	end
endmodule

// ### cmc_check_monitor.sv
// Purpose: port checks of the master control block
// Assumes: one clock, reset async low
// Notes: bound to the master control module
`timescale 1ns/1ps
module cmc_check_monitor (
	input wire clk_sys,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire can_tx,
	input wire bus_idle,
	input wire tx_check_valid,
	input wire tx_check_block,
	input wire [2:0] tx_byte_index,
	input wire [2:0] tx_byte_lane,
	input wire byte_order_select,
	input wire loop_frame_done,
	input wire rx_any_configured,
	input wire rx_match_valid,
	input wire loop_store,
	input wire [4:0] loop_mailbox,
	input wire loop_discard,
	input wire id_store_enable,
	input wire self_ack_enable,
	input wire soft_reset,
	input wire tx_cancel
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire wr_ctrl = reg_wr && reg_addr == 8'h00;
	wire rd_ctrl = reg_rd && reg_addr == 8'h00;
	wire lp = loop_frame_done && self_ack_enable;
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside answer cycle");
	a_reset_bit_reads: assert property (rd_ctrl |=> !reg_rdata[5])
		else $error("software reset bit read as one");
	a_swrst_pulse: assert property ($past(rst_n) |->
		soft_reset == ($past(wr_ctrl) && $past(reg_wdata[5])))
		else $error("soft reset pulse wrong");
	a_cancel_idle: assert property (tx_cancel |-> $past(bus_idle))
		else $error("cancel without idle bus");
	a_block_valid: assert property (tx_check_block |-> tx_check_valid)
		else $error("block without query");
	a_self_quiet: assert property (self_ack_enable &&
		$past(self_ack_enable) |-> can_tx)
		else $error("self test drives bus");
	a_id_store: assert property (id_store_enable != self_ack_enable)
		else $error("identifier stored in self test");
	a_lane_order: assert property ($past(rst_n) |->
		tx_byte_lane == ($past(byte_order_select) ? $past(tx_byte_index)
		: 3'h7 - $past(tx_byte_index)))
		else $error("byte lane order wrong");
	a_loop_zero: assert property (lp && !rx_any_configured |=>
		loop_store && loop_mailbox == 5'h00)
		else $error("loop frame not in mailbox zero");
	a_loop_drop: assert property (lp && rx_any_configured &&
		!rx_match_valid |=> loop_discard && !loop_store)
		else $error("unmatched loop frame kept");
	cover property (soft_reset);
	cover property (tx_cancel);
	cover property (loop_discard);
endmodule
bind cmc_master_control cmc_check_monitor cmc_check_monitor_i (.clk_sys,
	.rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .can_tx,
	.bus_idle, .tx_check_valid, .tx_check_block, .tx_byte_index,
	.tx_byte_lane, .byte_order_select, .loop_frame_done, .rx_any_configured,
	.rx_match_valid, .loop_store, .loop_mailbox, .loop_discard,
	.id_store_enable, .self_ack_enable, .soft_reset, .tx_cancel);

// ### testbench.sv
// Purpose: self-checking bench of the master control block
// Assumes: register port with one-cycle read answer
// Notes: reads checked through a queue of expected words
`timescale 1ns/1ps
module testbench;
	reg clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	reg protected_write_privilege = 1'b0, compatibility_mode = 1'b0;
	reg bus_idle = 1'b0, bus_off_entry = 1'b0, tx_check_valid = 1'b0;
	reg loop_frame_done = 1'b0, rx_any_configured = 1'b0;
	reg rx_match_valid = 1'b0, other_dom = 1'b0, rd_seen = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0, rnd;
	reg [4:0] tx_check_mailbox = 5'h00, rx_match_mailbox = 5'h05;
	reg [2:0] tx_byte_index = 3'h0;
	reg [2:0] rx_byte_index = 3'h0;
	reg tx_bit = 1'b1;
	wire [31:0] reg_rdata;
	wire [2:0] tx_byte_lane, rx_byte_lane;
	wire [4:0] loop_mailbox;
	wire can_tx, can_rx, bit_tick, tx_check_block, byte_order_select;
	wire loop_store, loop_discard, id_store_enable, self_ack_enable;
	wire powered_down, bus_off, soft_reset, tx_cancel;
	integer fail_count = 0, comparisons = 0, i, o;
	reg [31:0] exp_q[$];
	cmc_master_control cmc_master_control_i (.clk_sys, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .protected_write_privilege,
		.compatibility_mode, .can_rx, .can_tx, .bit_tick, .bus_idle,
		.bus_off_entry, .tx_bit, .tx_check_valid, .tx_check_mailbox,
		.tx_check_block, .tx_byte_index, .tx_byte_lane,
		.rx_byte_index, .rx_byte_lane, .byte_order_select,
		.loop_frame_done, .rx_any_configured, .rx_match_valid,
		.rx_match_mailbox, .loop_store, .loop_mailbox, .loop_discard,
		.id_store_enable, .self_ack_enable, .powered_down, .bus_off,
		.soft_reset, .tx_cancel);
	cmc_bus_model cmc_bus_model_i (.clk_sys, .rst_n, .can_tx, .other_dom,
		.can_rx, .bit_tick);
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	task cv(input [31:0] g, input [31:0] e);
	begin
		comparisons = comparisons + 1;
		if (g !== e) begin
			fail_count = fail_count + 1;
			$display("unexpected value at %0t: %h not %h", $time, g, e);
		end
	end
	endtask
	task w(input [7:0] a, input [31:0] d);
	begin
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	end
	endtask
	task r(input [7:0] a, input [31:0] e);
	begin
		@(posedge clk_sys);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	end
	endtask
	task give_verdict;
	begin
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	// read answers in order of request
	always @(posedge clk_sys) rd_seen <= reg_rd;
	always @(negedge clk_sys) begin
		if (rd_seen)
			cv(reg_rdata, exp_q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count = fail_count + 1;
		give_verdict;
	end
	initial begin
		rnd = $urandom(32'h6f12);
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		r(8'h00, 32'h0);
		r(8'h04, 32'h0);
		r(8'h08, 32'h0);
		w(8'h00, 32'h1fd3);
		r(8'h00, 32'h113);
		compatibility_mode <= 1'b1;
		rnd = $urandom | 32'h10;
		w(8'h00, {27'h0, rnd[4:0]});
		r(8'h00, {28'h0, rnd[3:0]});
		compatibility_mode <= 1'b0;
		protected_write_privilege <= 1'b1;
		for (o = 0; o < 2; o = o + 1) begin
			w(8'h00, o ? 32'h400 : 32'h0);
			for (i = 0; i < 8; i = i + 1) begin
				@(posedge clk_sys);
				rnd = $urandom;
				tx_byte_index <= rnd[2:0];
				rx_byte_index <= rnd[5:3];
				@(posedge clk_sys);
				@(negedge clk_sys);
				cv(tx_byte_lane, o ? rnd[2:0] : 3'h7 - rnd[2:0]);
				cv(rx_byte_lane, o ? rnd[5:3] : 3'h7 - rnd[5:3]);
				cv(byte_order_select, o);
			end
		end
		w(8'h00, 32'h103);
		tx_check_valid <= 1'b1;
		tx_check_mailbox <= 5'h03;
		@(negedge clk_sys);
		cv(tx_check_block, 1'b1);
		@(posedge clk_sys);
		tx_check_mailbox <= 5'h04;
		@(negedge clk_sys);
		cv(tx_check_block, 1'b0);
		w(8'h00, 32'h003);
		tx_check_mailbox <= 5'h03;
		@(negedge clk_sys);
		cv(tx_check_block, 1'b0);
		w(8'h00, 32'h503);
		w(8'h00, 32'h420);
		@(negedge clk_sys);
		cv(tx_check_block, 1'b0);
		cv(soft_reset, 1'b1);
		r(8'h04, 32'h8);
		bus_idle <= 1'b1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		cv(tx_cancel, 1'b1);
		r(8'h00, 32'h400);
		w(8'h00, 32'ha00);
		@(posedge clk_sys);
		@(negedge clk_sys);
		cv(powered_down, 1'b1);
		@(posedge clk_sys);
		other_dom <= 1'b1;
		repeat (6) @(posedge clk_sys);
		other_dom <= 1'b0;
		@(negedge clk_sys);
		cv(powered_down, 1'b0);
		r(8'h00, 32'h200);
		w(8'h00, 32'h800);
		other_dom <= 1'b1;
		repeat (6) @(posedge clk_sys);
		other_dom <= 1'b0;
		@(negedge clk_sys);
		cv(powered_down, 1'b1);
		w(8'h00, 32'h0);
		@(posedge clk_sys);
		@(negedge clk_sys);
		cv(powered_down, 1'b0);
		for (o = 0; o < 2; o = o + 1) begin
			w(8'h00, o ? 32'h80 : 32'h0);
			bus_off_entry <= 1'b1;
			@(posedge clk_sys);
			bus_off_entry <= 1'b0;
			r(8'h00, o ? 32'h80 : 32'h1000);
			@(negedge clk_sys);
			cv(bus_off, 1'b1);
			repeat (3000) @(posedge clk_sys);
			@(negedge clk_sys);
			cv(bus_off, o ? 1'b0 : 1'b1);
			if (o == 0) begin
				r(8'h04, 32'h6);
				w(8'h00, 32'h0);
				@(posedge clk_sys);
				@(negedge clk_sys);
				cv(bus_off, 1'b0);
			end
		end
		@(posedge clk_sys);
		tx_bit <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		cv(can_tx, 1'b0);
		w(8'h00, 32'h40);
		@(posedge clk_sys);
		@(negedge clk_sys);
		cv({id_store_enable, self_ack_enable, can_tx}, 3'h3);
		for (o = 0; o < 3; o = o + 1) begin
			@(posedge clk_sys);
			rx_any_configured <= o != 0;
			rx_match_valid <= o == 1;
			loop_frame_done <= 1'b1;
			@(posedge clk_sys);
			loop_frame_done <= 1'b0;
			@(negedge clk_sys);
			cv({loop_store, loop_discard}, o == 2 ? 2'h1 : 2'h2);
			if (o < 2)
				cv(loop_mailbox, o ? 5'h05 : 5'h00);
		end
		repeat (4) @(posedge clk_sys);
		give_verdict;
	end
endmodule
